//--- design/motion_seq_pkg.sv
package motion_seq_pkg;
  localparam logic [7:0]  MODE_TABLE      = 8'hFF;     // Minus one
  // Command word fields
  localparam int          CMD_SWITCH_ON   = 0;
  localparam int          CMD_EN_VOLTAGE  = 1;
  localparam int          CMD_QSTOP_N     = 2;
  localparam int          CMD_EN_OPER     = 3;
  localparam int          CMD_SEQ         = 4;
  localparam int          CMD_RESUME      = 6;
  localparam int          CMD_FAULT_RST   = 7;
  localparam int          CMD_HALT        = 8;
  localparam int          CMD_START       = 9;
  localparam int          CMD_SEL_LSB     = 11;
  localparam int          CMD_SEL_W       = 5;
  // State word fields
  localparam int          ST_READY        = 0;
  localparam int          ST_SWITCHED_ON  = 1;
  localparam int          ST_OPER_EN      = 2;
  localparam int          ST_FAULT        = 3;
  localparam int          ST_VOLTAGE      = 4;
  localparam int          ST_QSTOP_N      = 5;
  localparam int          ST_BUSY         = 8;
  localparam int          ST_TARGET       = 10;
  localparam int          ST_IN_GEAR      = 12;
  localparam int          ST_FOLLOW_ERR   = 13;
  // Register addresses on the plain port
  localparam logic [3:0]  ADDR_COMMAND    = 4'h0;
  localparam logic [3:0]  ADDR_STATE      = 4'h1;
  localparam logic [3:0]  ADDR_MODE       = 4'h2;
  localparam logic [3:0]  ADDR_ACT_BLOCK  = 4'h3;
  localparam logic [3:0]  ADDR_RES_BLOCK  = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h5;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h6;
  // Reset values
  localparam logic [15:0] COMMAND_RST     = 16'h0000;
  localparam logic [7:0]  MODE_RST        = 8'h00;
  localparam logic [15:0] NO_BLOCK        = 16'hFFFF;  // Minus one
  localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;
  // Interrupt status bits
  localparam int          IRQ_START       = 0;
  localparam int          IRQ_DONE        = 1;
  localparam int          IRQ_INTERRUPT   = 2;
  localparam int          IRQ_TARGET      = 3;
  localparam int          IRQ_W           = 4;
  // Next-block codes that end a chain: 0, -1, -2, -3
  localparam logic [7:0]  NEXT_END        = 8'h00;
  localparam logic [7:0]  NEXT_ERR_STOP   = 8'hFF;
  localparam logic [7:0]  NEXT_STOP_ERR   = 8'hFE;
  localparam logic [7:0]  NEXT_ESTOP_ERR  = 8'hFD;
  typedef enum logic [1:0] {RUN_IDLE, RUN_MOVE, RUN_HALT, RUN_STOPPING} run_state_t;
endpackage

//--- design/motion_block_table_sequencer.sv
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module motion_block_table_sequencer
  import motion_seq_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic      [5:0]  block_num,
  output logic             block_go,
  output logic             block_stop,
  input  wire logic        block_done,
  input  wire logic [7:0]  block_next,
  input  wire logic        block_positioning,
  input  wire logic        pos_in_window,
  input  wire logic        axis_zero_speed,
  input  wire logic        gear_coupled,
  input  wire logic        following_error,
  input  wire logic        drive_fault,
  output logic             irq
);
  import motion_seq_pkg::*;

  typedef struct packed {
    logic [1:0]  in_gear_s;
    logic [1:0]  follow_s;
    logic [1:0]  fault_s;
    logic [15:0] command;
    logic [7:0]  mode;
    logic        start_prev;
    run_state_t  run;
    logic        seq_mode;
    logic [5:0]  act_block;
    logic [15:0] res_block;
    logic        target;
    logic        busy;
    logic        fault;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [15:0] rdata;
    logic        go;
    logic        stop;
    logic        irq;
  } state_t;

  state_t cur_r;
  state_t cur_nxt;

  // Start block from the select field, 1..32
  function automatic logic [5:0] sel_block(input logic [15:0] cmd);
    sel_block = {1'b0, cmd[CMD_SEL_LSB +: CMD_SEL_W]} + 6'h01;
  endfunction

  // Next-block codes that close a chain
  function automatic logic chain_end(input logic [7:0] nxt);
    chain_end = (nxt == NEXT_END) || (nxt == NEXT_ERR_STOP) ||
                (nxt == NEXT_STOP_ERR) || (nxt == NEXT_ESTOP_ERR);
  endfunction

  function automatic logic [15:0] state_word(input state_t s);
    logic [15:0] w;
    logic        ena;
    w   = 16'h0000;
    ena = s.command[CMD_SWITCH_ON] & s.command[CMD_EN_VOLTAGE] & s.command[CMD_QSTOP_N] & ~s.fault;
    w[ST_READY]       = s.command[CMD_EN_VOLTAGE] & s.command[CMD_QSTOP_N] & ~s.fault;
    w[ST_SWITCHED_ON] = ena;
    w[ST_OPER_EN]     = ena & s.command[CMD_EN_OPER];
    w[ST_FAULT]       = s.fault;
    w[ST_VOLTAGE]     = s.command[CMD_EN_VOLTAGE];
    w[ST_QSTOP_N]     = s.command[CMD_QSTOP_N];
    w[ST_BUSY]        = s.busy;
    w[ST_TARGET]      = s.target;
    w[ST_IN_GEAR]     = s.in_gear_s[1];
    w[ST_FOLLOW_ERR]  = s.follow_s[1];
    state_word = w;
  endfunction

  // All behaviour in one next-state process
  always_comb begin
    logic start_edge;
    logic oper_ok;
    logic halt;
    logic [IRQ_W-1:0] ev;
    start_edge = 1'b0;
    oper_ok    = 1'b0;
    halt       = 1'b0;
    ev         = '0;
    cur_nxt    = cur_r;
    cur_nxt.go = 1'b0;
    // Two-stage synchronisers for drive-side levels
    cur_nxt.in_gear_s = {cur_r.in_gear_s[0], gear_coupled};
    cur_nxt.follow_s  = {cur_r.follow_s[0], following_error};
    cur_nxt.fault_s   = {cur_r.fault_s[0], drive_fault};

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_COMMAND:  cur_nxt.command  = reg_wdata;
        ADDR_MODE:     cur_nxt.mode     = reg_wdata[7:0];
        ADDR_IRQ_MASK: cur_nxt.irq_mask = reg_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // Fault latch, cleared by a fault-reset request
    if (cur_r.fault_s[1]) begin
      cur_nxt.fault = 1'b1;
    end else if (cur_r.command[CMD_FAULT_RST]) begin
      cur_nxt.fault = 1'b0;
    end

    oper_ok = (cur_r.mode == MODE_TABLE) && cur_r.command[CMD_SWITCH_ON] && cur_r.command[CMD_EN_VOLTAGE] &&
              cur_r.command[CMD_QSTOP_N] && cur_r.command[CMD_EN_OPER] && !cur_r.fault;
    halt       = cur_r.command[CMD_HALT];
    start_edge = cur_r.command[CMD_START] && !cur_r.start_prev;
    cur_nxt.start_prev = cur_r.command[CMD_START];

    unique case (cur_r.run)
      RUN_IDLE: begin
        cur_nxt.stop = 1'b0;
        if (oper_ok && start_edge) begin
          // Mode and start block latched only here, later edits wait for the next edge
          cur_nxt.seq_mode = cur_r.command[CMD_SEQ];
          if (cur_r.command[CMD_RESUME] && cur_r.res_block != NO_BLOCK) begin
            cur_nxt.act_block = cur_r.res_block[5:0];
          end else begin
            cur_nxt.act_block = sel_block(cur_r.command);
          end
          cur_nxt.res_block = NO_BLOCK;
          cur_nxt.go        = 1'b1;
          cur_nxt.busy      = 1'b1;
          cur_nxt.target    = 1'b0;
          cur_nxt.run       = RUN_MOVE;
          ev[IRQ_START]     = 1'b1;
        end
      end
      RUN_MOVE, RUN_HALT: begin
        if (!oper_ok || !cur_r.command[CMD_START]) begin
          // Interrupt: ramp down, remember block for resume
          cur_nxt.stop      = 1'b1;
          cur_nxt.res_block = {10'h000, cur_r.act_block};
          cur_nxt.run       = RUN_STOPPING;
          ev[IRQ_INTERRUPT] = 1'b1;
        end else if (halt) begin
          cur_nxt.stop   = 1'b1;
          cur_nxt.run    = RUN_HALT;
          cur_nxt.target = axis_zero_speed;
        end else if (cur_r.run == RUN_HALT) begin
          cur_nxt.stop   = 1'b0;
          cur_nxt.target = 1'b0;
          cur_nxt.run    = RUN_MOVE;
        end else begin
          cur_nxt.target = block_positioning && pos_in_window;
          if (block_done) begin
            if (!cur_r.seq_mode || chain_end(block_next)) begin
              cur_nxt.busy = 1'b0;
              cur_nxt.run  = RUN_IDLE;
              ev[IRQ_DONE] = 1'b1;
            end else begin
              // Next block taken from the table's link
              cur_nxt.act_block = block_next[5:0];
              cur_nxt.go        = 1'b1;
            end
          end
        end
      end
      RUN_STOPPING: begin
        cur_nxt.target = halt & axis_zero_speed;
        if (axis_zero_speed) begin
          cur_nxt.busy = 1'b0;
          cur_nxt.stop = 1'b0;
          cur_nxt.run  = RUN_IDLE;
        end
      end
      default: cur_nxt.run = RUN_IDLE;
    endcase
    if (cur_r.target == 1'b0 && cur_nxt.target) begin
      ev[IRQ_TARGET] = 1'b1;
    end

    // Register reads, one cycle latency
    cur_nxt.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_COMMAND:   cur_nxt.rdata = cur_r.command;
        ADDR_STATE:     cur_nxt.rdata = state_word(cur_r);
        ADDR_MODE:      cur_nxt.rdata = {8'h00, cur_r.mode};
        ADDR_ACT_BLOCK: cur_nxt.rdata = {10'h000, cur_r.act_block};
        ADDR_RES_BLOCK: cur_nxt.rdata = cur_r.res_block;
        ADDR_IRQ_STAT:  cur_nxt.rdata = {{(16-IRQ_W){1'b0}}, cur_r.irq_stat};
        ADDR_IRQ_MASK:  cur_nxt.rdata = {{(16-IRQ_W){1'b0}}, cur_r.irq_mask};
        default:        cur_nxt.rdata = 16'h0000;
      endcase
    end

    // Read clears status; a same-cycle event wins
    if (reg_rd && reg_addr == ADDR_IRQ_STAT) begin
      cur_nxt.irq_stat = ev;
    end else begin
      cur_nxt.irq_stat = cur_r.irq_stat | ev;
    end
    cur_nxt.irq = |(cur_nxt.irq_stat & cur_nxt.irq_mask);
  end

  // Single state register, frozen while clk_en is low
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_r          <= '0;
      cur_r.command  <= COMMAND_RST;
      cur_r.mode     <= MODE_RST;
      cur_r.run      <= RUN_IDLE;
      cur_r.res_block <= NO_BLOCK;
      cur_r.irq_mask <= IRQ_MASK_RST;
    end else if (clk_en) begin
      cur_r <= cur_nxt;
    end
  end

  assign reg_rdata  = cur_r.rdata;
  assign block_num  = cur_r.act_block;
  assign block_go   = cur_r.go;
  assign block_stop = cur_r.stop;
  assign irq        = cur_r.irq;
endmodule

//--- bench/motion_seq_monitor.sv
`timescale 1ns/1ps
module motion_seq_monitor
  import motion_seq_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [5:0]  block_num,
  input wire logic        block_go,
  input wire logic        block_stop,
  input wire logic        gear_coupled,
  input wire logic        irq
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // Command writes that start, or that stop or halt a move
  wire logic cmd_wr  = reg_wr && reg_addr == ADDR_COMMAND;
  wire logic stop_wr = cmd_wr && (!reg_wdata[CMD_START] || reg_wdata[CMD_HALT]);
  sequence sel_start;
    cmd_wr && reg_wdata[CMD_START] && !reg_wdata[CMD_RESUME] ##2 block_go;
  endsequence
  sequence state_rd;
    clk_en && reg_rd && reg_addr == ADDR_STATE;
  endsequence
  a_go_one_cycle: assert property (block_go |=> !block_go) else $error("start pulse too long");
  a_go_in_range: assert property (block_go |-> block_num inside {[6'd1:6'd32]})
    else $error("block out of range");
  a_start_num: assert property (sel_start |-> block_num == $past(reg_wdata[15:11], 2) + 6'd1)
    else $error("start block not select plus one");
  a_rdata_idle: assert property (clk_en && !reg_rd |=> reg_rdata == 16'h0000) else $error("stray read data");
  a_rdata_unmapped: assert property (clk_en && reg_rd && reg_addr > ADDR_IRQ_MASK |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_stop_cause: assert property ($rose(block_stop) |-> $past(stop_wr, 2) || $past(stop_wr))
    else $error("stop without command");
  a_gear_on: assert property (gear_coupled [*4] ##0 state_rd |=> reg_rdata[ST_IN_GEAR])
    else $error("in gear bit missing");
  a_gear_off: assert property (!gear_coupled [*4] ##0 state_rd |=> !reg_rdata[ST_IN_GEAR])
    else $error("in gear bit stuck");
  a_irq_masked: assert property (reg_wr && reg_addr == ADDR_IRQ_MASK && reg_wdata[3:0] == 4'h0 |-> ##2 !irq)
    else $error("masked interrupt raised");
endmodule

bind motion_block_table_sequencer motion_seq_monitor monitor_i (
  .sys_clk, .reset_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .block_num, .block_go, .block_stop, .gear_coupled, .irq
);

//--- bench/motion_engine_model.sv
`timescale 1ns/1ps
module motion_engine_model #(
  parameter int DLY = 12
) (
  input  wire logic       sys_clk,
  input  wire logic [5:0] block_num,
  input  wire logic       block_go,
  input  wire logic       block_stop,
  input  wire logic [7:0] end_code,
  output logic            block_done,
  output logic [7:0]      block_next,
  output logic            pos_in_window,
  output logic            axis_zero_speed
);
  int         cnt = 0;
  int         ramp = 0;
  logic [7:0] code;
  // Travel counts down; a stop freezes it, zero speed after a short ramp
  always @(posedge sys_clk) begin
    block_done <= 1'b0;
    ramp <= block_stop ? ramp + 1 : 0;
    if (block_go) cnt <= DLY;
    else if (cnt > 0 && !block_stop) begin
      cnt <= cnt - 1;
      block_done <= cnt == 1;
    end
  end
  // Blocks 4 and 5 chain on; others end with the code the bench picks
  assign code = (block_num == 6'd4 || block_num == 6'd5) ? {2'b00, block_num + 6'd1} : end_code;
  // Not valid away from the done pulse, so show the inverse there
  assign block_next = block_done ? code : ~code;
  assign pos_in_window = cnt == 1 || cnt == 2;
  assign axis_zero_speed = cnt == 0 || ramp > 3;
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import motion_seq_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        gear_coupled = 1'b0;
  logic [7:0]  end_code = 8'h00;
  logic        drive_fault = 1'b0;
  logic        following_error = 1'b0;
  logic [15:0] reg_rdata, d;
  logic [5:0]  block_num;
  logic [7:0]  block_next;
  logic        block_go, block_stop, block_done, pos_in_window, axis_zero_speed, irq;
  int          fails = 0;
  int          n_compared = 0;
  int          cyc = 0;

  motion_block_table_sequencer motion_block_table_sequencer_i (
    .sys_clk, .reset_n, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .block_num, .block_go, .block_stop, .block_done, .block_next, .block_positioning(1'b1),
    .pos_in_window, .axis_zero_speed, .gear_coupled, .following_error, .drive_fault, .irq);
  motion_engine_model #(.DLY(12)) motion_engine_model_i (
    .sys_clk, .block_num, .block_go, .block_stop, .end_code, .block_done, .block_next,
    .pos_in_window, .axis_zero_speed);

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // Hang guard, far above the few hundred cycles of the run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %0t got %h expected %h", $time, s, e);
    end
  endtask
  // Strobe is dropped and an idle edge passes, so calls never collide
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    v = reg_rdata;
  endtask
  task automatic wt(ref logic s, input logic v);
    int i;
    for (i = 0; i < 60 && s !== v; i++) @(posedge sys_clk);
    if (i == 60) chk(16'h0000, 16'h0001);
  endtask
  task automatic stb(input int b, input logic e);
    rd(ADDR_STATE, d);
    chk({15'h0000, d[b]}, {15'h0000, e});
  endtask
  task automatic go(input logic [4:0] s, input logic [10:0] f);
    wr(ADDR_COMMAND, {s, f});
    wr(ADDR_COMMAND, {s, f | 11'h200});
    wt(block_go, 1'b1);
  endtask
  task automatic t_reset;
    rd(ADDR_RES_BLOCK, d);
    chk(d, NO_BLOCK);
    rd(4'hF, d);
    chk(d, 16'h0000);
    wr(ADDR_COMMAND, 16'h000F);
    wr(ADDR_COMMAND, 16'h020F);
    repeat (2) @(posedge sys_clk);
    stb(ST_BUSY, 1'b0);
    wr(ADDR_MODE, {8'h00, MODE_TABLE});
    wr(ADDR_IRQ_MASK, 16'h000F);
  endtask
  task automatic t_single;
    logic [4:0] sel [4] = '{5'd0, 5'd3, 5'd16, 5'd31};
    foreach (sel[k]) begin
      go(sel[k], 11'h00F);
      chk({10'h000, block_num}, {11'h000, sel[k]} + 16'h0001);
      wr(ADDR_COMMAND, {~sel[k], 11'h21F});
      stb(ST_BUSY, 1'b1);
      wt(block_done, 1'b1);
      stb(ST_BUSY, 1'b0);
    end
  endtask
  task automatic t_irq;
    rd(ADDR_IRQ_STAT, d);
    wr(ADDR_IRQ_MASK, 16'h0000);
    go(5'd1, 11'h00F);
    wt(block_done, 1'b1);
    repeat (2) @(posedge sys_clk);
    chk({15'h0000, irq}, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h0002);
    repeat (2) @(posedge sys_clk);
    chk({15'h0000, irq}, 16'h0001);
    rd(ADDR_IRQ_STAT, d);
    chk(d, 16'h000B);
    chk({15'h0000, irq}, 16'h0000);
  endtask
  task automatic t_chain;
    logic [7:0] codes [4] = '{NEXT_END, NEXT_ERR_STOP, NEXT_STOP_ERR, NEXT_ESTOP_ERR};
    foreach (codes[c]) begin
      end_code <= codes[c];
      go(5'd3, 11'h01F);
      for (int k = 4; k <= 6; k++) begin
        if (k > 4) wt(block_go, 1'b1);
        chk({10'h000, block_num}, k[15:0]);
        if (k == 5) begin
          rd(ADDR_ACT_BLOCK, d);
          chk(d, 16'h0005);
          stb(ST_BUSY, 1'b1);
        end
        wt(block_done, 1'b1);
      end
      stb(ST_BUSY, 1'b0);
    end
  endtask
  task automatic t_resume;
    go(5'd3, 11'h01F);
    wt(block_done, 1'b1);
    wt(block_go, 1'b1);
    wr(ADDR_COMMAND, {5'd3, 11'h01F});
    wt(block_stop, 1'b1);
    wt(block_stop, 1'b0);
    stb(ST_BUSY, 1'b0);
    rd(ADDR_RES_BLOCK, d);
    chk(d, 16'h0005);
    // Let the engine run off the frozen move before restarting
    repeat (12) @(posedge sys_clk);
    go(5'd0, 11'h05F);
    chk({10'h000, block_num}, 16'h0005);
    wt(block_done, 1'b1);
    wt(block_go, 1'b1);
    chk({10'h000, block_num}, 16'h0006);
    wt(block_done, 1'b1);
    rd(ADDR_RES_BLOCK, d);
    chk(d, NO_BLOCK);
    go(5'd7, 11'h04F);
    chk({10'h000, block_num}, 16'h0008);
    wt(block_done, 1'b1);
  endtask
  task automatic t_halt;
    go(5'd0, 11'h00F);
    wr(ADDR_COMMAND, 16'h030F);
    wt(block_stop, 1'b1);
    wt(axis_zero_speed, 1'b1);
    stb(ST_TARGET, 1'b1);
    stb(ST_BUSY, 1'b1);
    wr(ADDR_COMMAND, 16'h020F);
    wt(block_stop, 1'b0);
    wt(block_done, 1'b1);
    gear_coupled <= 1'b1;
    repeat (4) @(posedge sys_clk);
    stb(ST_IN_GEAR, 1'b1);
    gear_coupled <= 1'b0;
    repeat (4) @(posedge sys_clk);
    stb(ST_IN_GEAR, 1'b0);
  endtask
  // Drive fault latches until a fault-reset command after the fault is gone
  task automatic t_fault;
    drive_fault <= 1'b1;
    following_error <= 1'b1;
    repeat (4) @(posedge sys_clk);
    stb(ST_FAULT, 1'b1);
    stb(ST_FOLLOW_ERR, 1'b1);
    drive_fault <= 1'b0;
    following_error <= 1'b0;
    repeat (4) @(posedge sys_clk);
    stb(ST_FAULT, 1'b1);
    wr(ADDR_COMMAND, 16'h008F);
    wr(ADDR_COMMAND, 16'h000F);
    stb(ST_FAULT, 1'b0);
    stb(ST_FOLLOW_ERR, 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_single();
    t_irq();
    t_chain();
    t_resume();
    t_halt();
    t_fault();
    give_verdict();
  end
endmodule
